// ===== hdl/mxbar_switch.sv
// Crossbar switch: three masters, three slaves, priority plus round-robin arbitration
//
// Overview of operation
// - Three masters, three slaves, parallel connections.
// - Address and data paths are 32 bits.
// - Two transfers at most; one is flash fetch.
// - Highest priority requester wins the slave.
// - Losers wait until the owner finishes.
// - Equal priority rotates after last granted master.
//
// Structure
// One arbiter per slave port, idle or busy, all held in one packed state.
// An idle port scans the masters that address it, starting after the one
// granted last, and keeps the first requester of the highest priority.
// Only a strictly higher priority replaces the current pick, so equal
// priorities keep the rotation order.
// A busy port holds the owner's address, write data and direction latched at grant,
// and waits for the slave's done pulse.
// On done the owner sees its own done pulse with the read data and loses
// its grant; it must drop its request in that cycle, or it may be
// granted again at the next edge.
// Masters that lose stay ungranted and are scanned again every cycle.
//
// Concurrency
// Slave 0 is the internal flash and master 0 the instruction side.
// With one transfer running, a second one may start only if one of the
// two is an instruction fetch by master 0 from slave 0.
// With two transfers running, no further request is granted.
`timescale 1ns/1ps
module mxbar_switch
   import mxbar_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Master side requests
   input wire logic [MXBAR_NUM_M-1:0] m_req,
   input wire logic [MXBAR_NUM_M-1:0] m_ifetch,
   input wire logic [MXBAR_NUM_M-1:0] m_write,
   input wire logic [MXBAR_NUM_M*2-1:0] m_sel,
   input wire logic [MXBAR_NUM_M*MXBAR_PRIO_W-1:0] m_prio,
   input wire logic [MXBAR_NUM_M*MXBAR_ADDR_W-1:0] m_addr,
   input wire logic [MXBAR_NUM_M*MXBAR_DATA_W-1:0] m_wdata,
   // Master side answers
   output logic [MXBAR_NUM_M-1:0] m_grant,
   output logic [MXBAR_NUM_M-1:0] m_done,
   output logic [MXBAR_NUM_M*MXBAR_DATA_W-1:0] m_rdata,
   // Slave side requests
   output logic [MXBAR_NUM_S-1:0] s_req,
   output logic [MXBAR_NUM_S-1:0] s_write,
   output logic [MXBAR_NUM_S*MXBAR_ADDR_W-1:0] s_addr,
   output logic [MXBAR_NUM_S*MXBAR_DATA_W-1:0] s_wdata,
   // Slave side answers
   input wire logic [MXBAR_NUM_S-1:0] s_done,
   input wire logic [MXBAR_NUM_S*MXBAR_DATA_W-1:0] s_rdata
);

   // Whole state of the switch
   // Per-port fields are indexed by slave, per-master fields by master
   typedef struct packed {
      mxbar_arb_type [MXBAR_NUM_S-1:0] arb; // Arbitration state per slave
      logic [MXBAR_NUM_S-1:0][1:0] owner; // Current owner per slave
      logic [MXBAR_NUM_S-1:0][1:0] last; // Last granted master per slave
      logic [MXBAR_NUM_M-1:0] grant; // Grant per master
      logic [MXBAR_NUM_M-1:0] done; // Done pulse per master
      logic [MXBAR_NUM_M*MXBAR_DATA_W-1:0] rdata; // Read data per master
      logic [MXBAR_NUM_S-1:0] req; // Slave request
      logic [MXBAR_NUM_S-1:0] write; // Slave direction
      logic [MXBAR_NUM_S*MXBAR_ADDR_W-1:0] addr; // Slave address
      logic [MXBAR_NUM_S*MXBAR_DATA_W-1:0] wdata; // Slave write data
   } mxbar_state_type;

   // The flops hold state; the comb process below fills next_state
   mxbar_state_type state; // Registered state
   mxbar_state_type next_state; // Next state

   // Next state computation
   // Starts from the held state, so fields that no branch touches keep
   // their value; only the done pulses are cleared every cycle.
   // Working variables carry the running transfer count across the slave
   // loop, so two ports that go busy in one cycle see each other.
   always_comb begin
      logic [1:0] win; // Chosen master
      logic [MXBAR_PRIO_W-1:0] best; // Best priority so far
      logic [1:0] cand; // Candidate master in rotation
      logic found; // A winner was found
      logic [1:0] active; // Transfers in progress
      logic fetch_busy; // Flash fetch in progress
      logic [1:0] om; // Owner master index
      win = MXBAR_NONE;
      best = '0;
      cand = '0;
      found = 1'b0;
      active = '0;
      fetch_busy = 1'b0;
      om = '0;
      next_state = state;
      next_state.done = '0;
      // Count transfers already running
      for (int s = 0; s < MXBAR_NUM_S; s++) begin
         if (state.arb[s] == MXBAR_BUSY) begin
            active = active + 2'h1;
            // A flash transfer of master 0 counts as a fetch only while
            // that master flags it as one
            if (s == int'(MXBAR_FLASH_S) && state.owner[s] == MXBAR_IFETCH_M &&
                m_ifetch[MXBAR_IFETCH_M]) begin
               fetch_busy = 1'b1;
            end
         end
      end
      // Arbitrate each slave port in turn; the flash port comes first,
      // so a fetch claims the second slot before the other ports
      for (int s = 0; s < MXBAR_NUM_S; s++) begin
         case (state.arb[s])
            // Look for a new owner
            MXBAR_IDLE: begin
               found = 1'b0;
               win = MXBAR_NONE;
               best = '0;
               // Scan masters starting after the last granted one
               // Only masters that address this port and hold no grant take part
               for (int k = 1; k <= MXBAR_NUM_M; k++) begin
                  cand = 2'((int'(state.last[s]) + k) % MXBAR_NUM_M);
                  if (m_req[cand] && !state.grant[cand] && m_sel[cand*2 +: 2] == 2'(s)) begin
                     // Strictly higher priority replaces, ties keep rotation order
                     if (!found || m_prio[cand*MXBAR_PRIO_W +: MXBAR_PRIO_W] > best) begin
                        win = cand;
                        best = m_prio[cand*MXBAR_PRIO_W +: MXBAR_PRIO_W];
                        found = 1'b1;
                     end
                  end
               end
               // Concurrency limit: one of two transfers must be a flash fetch
               // A blocked winner is not granted and retries next cycle
               if (found) begin
                  if (active >= 2'h2) begin
                     // Both slots taken
                     found = 1'b0;
                  end else if (active == 2'h1 && !fetch_busy) begin
                     // Running transfer is no fetch, so this one must be
                     if (!(s == int'(MXBAR_FLASH_S) && win == MXBAR_IFETCH_M &&
                           m_ifetch[win])) begin
                        found = 1'b0;
                     end
                  end
               end
               // Take the port and latch the winner's request
               if (found) begin
                  active = active + 2'h1;
                  if (s == int'(MXBAR_FLASH_S) && win == MXBAR_IFETCH_M && m_ifetch[win]) begin
                     fetch_busy = 1'b1;
                  end
                  next_state.arb[s] = MXBAR_BUSY;
                  next_state.owner[s] = win;
                  next_state.last[s] = win;
                  next_state.grant[win] = 1'b1;
                  next_state.req[s] = 1'b1;
                  next_state.write[s] = m_write[win];
                  next_state.addr[s*MXBAR_ADDR_W +: MXBAR_ADDR_W] =
                     m_addr[win*MXBAR_ADDR_W +: MXBAR_ADDR_W];
                  next_state.wdata[s*MXBAR_DATA_W +: MXBAR_DATA_W] =
                     m_wdata[win*MXBAR_DATA_W +: MXBAR_DATA_W];
               end
            end
            // Hold the connection until the slave completes
            // Other masters addressing this port stay stalled meanwhile
            MXBAR_BUSY: begin
               om = state.owner[s];
               // Release the port, pulse done, return the read word
               if (s_done[s]) begin
                  next_state.arb[s] = MXBAR_IDLE;
                  next_state.owner[s] = MXBAR_NONE;
                  next_state.req[s] = 1'b0;
                  next_state.grant[om] = 1'b0;
                  next_state.done[om] = 1'b1;
                  next_state.rdata[om*MXBAR_DATA_W +: MXBAR_DATA_W] =
                     s_rdata[s*MXBAR_DATA_W +: MXBAR_DATA_W];
               end
            end
            // Recover from an illegal code
            // The port falls back to idle with no owner and no request
            default: begin
               next_state.arb[s] = MXBAR_IDLE;
               next_state.owner[s] = MXBAR_NONE;
               next_state.req[s] = 1'b0;
            end
         endcase
      end
   end

   // State register
   // Reset leaves every port idle with no owner and no request out.
   // The rotation pointer starts at the last master, so master 0 wins
   // the first tie on any port.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int s = 0; s < MXBAR_NUM_S; s++) begin
            state.arb[s] <= MXBAR_IDLE;
            state.owner[s] <= MXBAR_NONE;
            state.last[s] <= MXBAR_LAST_RST;
         end
         state.grant <= '0;
         state.done <= '0;
         state.rdata <= '0;
         state.req <= '0;
         state.write <= '0;
         state.addr <= '0;
         state.wdata <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from state flops
   // No output has a combinational path from an input; a master sees
   // its grant right after the edge that took its request.
   assign m_grant = state.grant;
   assign m_done = state.done;
   assign m_rdata = state.rdata;
   assign s_req = state.req;
   assign s_write = state.write;
   assign s_addr = state.addr;
   assign s_wdata = state.wdata;
endmodule

// ===== hdl/mxbar_pkg.sv
// Package with shared constants and types for the crossbar switch
package mxbar_pkg;
   localparam int MXBAR_ADDR_W = 32; // Address path width
   localparam int MXBAR_DATA_W = 32; // Data path width
   localparam int MXBAR_NUM_M = 3; // Master port count
   localparam int MXBAR_NUM_S = 3; // Slave port count
   localparam int MXBAR_PRIO_W = 2; // Priority field width
   localparam logic [1:0] MXBAR_LAST_RST = 2'h2; // Pointer reset: last master granted
   localparam logic [1:0] MXBAR_NONE = 2'h3; // No owner code
   localparam logic [1:0] MXBAR_FLASH_S = 2'h0; // Slave index of internal flash
   localparam logic [1:0] MXBAR_IFETCH_M = 2'h0; // Master index of instruction side
   // Per-slave arbitration states, one-hot
   typedef enum logic [1:0] {
      MXBAR_IDLE = 2'b01,
      MXBAR_BUSY = 2'b10
   } mxbar_arb_type;
endpackage

// ===== verification/mxbar_switch_monitor.sv
// Port assertions for the crossbar switch
`timescale 1ns/1ps
module mxbar_switch_monitor
   import mxbar_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Master side
   input wire logic [MXBAR_NUM_M-1:0] m_req,
   input wire logic [MXBAR_NUM_M-1:0] m_ifetch,
   input wire logic [MXBAR_NUM_M*2-1:0] m_sel,
   input wire logic [MXBAR_NUM_M-1:0] m_grant,
   input wire logic [MXBAR_NUM_M-1:0] m_done,
   // Slave side
   input wire logic [MXBAR_NUM_S-1:0] s_req,
   input wire logic [MXBAR_NUM_S-1:0] s_done
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_slave_done; |s_done; endsequence
   property p_conc; $countones(s_req) <= 2; endproperty
   property p_fetch; $countones(s_req) == 2 |-> s_req[0] && m_grant[0] && m_ifetch[0]
      && m_sel[1:0] == 2'h0; endproperty
   property p_pair; $countones(m_grant) == $countones(s_req); endproperty
   property p_pulse; (m_done & $past(m_done)) == 3'h0; endproperty
   property p_follow; s_slave_done |=> |m_done; endproperty
   property p_release; (m_done & m_grant) == 3'h0; endproperty
   property p_hold; ($past(s_req) & ~$past(s_done) & ~s_req) == 3'h0; endproperty
   property p_owner; (m_grant & ~m_req) == 3'h0; endproperty
   a_conc: assert property (p_conc) else $error("too many transfers");
   a_fetch: assert property (p_fetch) else $error("second transfer not a fetch");
   a_pair: assert property (p_pair) else $error("grant and slave mismatch");
   a_pulse: assert property (p_pulse) else $error("done too long");
   a_follow: assert property (p_follow) else $error("done missing");
   a_release: assert property (p_release) else $error("grant kept at done");
   a_hold: assert property (p_hold) else $error("slave dropped early");
   a_owner: assert property (p_owner) else $error("grant without request");
endmodule

// ===== verification/mxbar_slave_model.sv
// Behavioural slave ports answering the crossbar switch
`timescale 1ns/1ps
module mxbar_slave_model
   import mxbar_pkg::*;
#(parameter int DLY = 0)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Requests from the switch
   input wire logic [MXBAR_NUM_S-1:0] s_req,
   input wire logic [MXBAR_NUM_S*MXBAR_ADDR_W-1:0] s_addr,
   // Answers to the switch
   output logic [MXBAR_NUM_S-1:0] s_done,
   output logic [MXBAR_NUM_S*MXBAR_DATA_W-1:0] s_rdata
);
   logic [3:0] cnt [MXBAR_NUM_S]; // Wait count per slave
   // Read word from address, inverted outside the done cycle
   always_comb for (int j = 0; j < 3; j++)
      s_rdata[j*32+:32] = s_addr[j*32+:32] ^ (s_done[j] ? 32'h5A5A5A5A : 32'hA5A5A5A5);
   // Slave j answers DLY+j+1 cycles after its request
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_done <= '0;
         cnt <= '{default: 4'h0};
      end else begin
         for (int j = 0; j < 3; j++) begin
            s_done[j] <= s_req[j] && !s_done[j] && cnt[j] == 4'(DLY + j);
            cnt[j] <= (s_req[j] && !s_done[j]) ? cnt[j] + 4'h1 : 4'h0;
         end
      end
   end
endmodule

// ===== verification/tb_mxbar_switch.sv
// Testbench for the crossbar switch
`timescale 1ns/1ps
module tb_mxbar_switch;
   logic core_clk = 0, rst_b = 0;
   logic [2:0] m_req = 0, m_ifetch = 0, m_write = 3'h5, m_grant, m_done, s_req, s_write, s_done;
   logic [5:0] m_sel = 0, m_prio = 0;
   logic [95:0] m_addr = 96'h30000300_20000200_10000100;
   logic [95:0] m_wdata = 96'hC000000C_B000000B_A000000A;
   logic [95:0] m_rdata, s_addr, s_wdata, s_rdata;
   int n_fail = 0, check_count = 0, peak, order[$];
   initial forever #2 core_clk = ~core_clk;
   mxbar_switch mxbar_switch_inst(.core_clk(core_clk), .rst_b(rst_b), .m_req(m_req),
      .m_ifetch(m_ifetch), .m_write(m_write), .m_sel(m_sel), .m_prio(m_prio),
      .m_addr(m_addr), .m_wdata(m_wdata), .m_grant(m_grant), .m_done(m_done),
      .m_rdata(m_rdata), .s_req(s_req), .s_write(s_write), .s_addr(s_addr),
      .s_wdata(s_wdata), .s_done(s_done), .s_rdata(s_rdata));
   mxbar_slave_model #(.DLY(1)) mxbar_slave_model_inst(.core_clk(core_clk), .rst_b(rst_b),
      .s_req(s_req), .s_addr(s_addr), .s_done(s_done), .s_rdata(s_rdata));
   task summarize;
      if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Raise requests; drop each at the edge its slave completes; log order and peak grants
   task run(input logic [2:0] req, input logic [5:0] sel, prio, input logic [2:0] fetch);
      int k;
      logic [2:0] drop;
      order = {};
      peak = 0;
      @(posedge core_clk);
      {m_sel, m_prio, m_ifetch, m_req} <= {sel, prio, fetch, req};
      for (k = 0; k < 99 && (k < 2 || m_req !== 3'h0); k++) begin
         // Look at settled outputs mid-cycle
         @(negedge core_clk);
         drop = 3'h0;
         if ($countones(m_grant) > peak) peak = $countones(m_grant);
         for (int i = 0; i < 3; i++) begin
            if (m_done[i] === 1'b1) begin
               order.push_back(i);
               cmp(m_rdata[i*32+:32], m_addr[i*32+:32] ^ 32'h5A5A5A5A);
            end
            // Slave completes at the next edge, so the request drops there
            if (m_grant[i] === 1'b1 && s_done[m_sel[i*2+:2]] === 1'b1) drop[i] = 1'b1;
            // Owned slave port carries the owner's request unchanged
            if (m_grant[i] === 1'b1) begin
               cmp(s_addr[m_sel[i*2+:2]*32+:32], m_addr[i*32+:32]);
               cmp(s_wdata[m_sel[i*2+:2]*32+:32], m_wdata[i*32+:32]);
               cmp(32'(s_write[m_sel[i*2+:2]]), 32'(m_write[i]));
               cmp(32'(s_req[m_sel[i*2+:2]]), 32'h1);
            end
         end
         @(posedge core_clk);
         m_req <= m_req & ~drop;
      end
      if (k == 99) begin
         n_fail++;
         summarize;
      end
   endtask
   task t_rotate;
      run(3'b011, 6'h00, 6'h15, 3'h0);
      cmp(order[0], 0);
      cmp(order[1], 1);
      run(3'b101, 6'h00, 6'h15, 3'h0);
      cmp(order[0], 2);
   endtask
   task t_prio;
      run(3'b110, 6'h28, 6'h34, 3'h0);
      cmp(order[0], 2);
      cmp(order[1], 1);
      cmp(peak, 1);
   endtask
   task t_conc;
      run(3'b011, 6'h04, 6'h00, 3'h1);
      cmp(peak, 2);
      run(3'b110, 6'h24, 6'h00, 3'h0);
      cmp(peak, 1);
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      t_rotate;
      t_prio;
      t_conc;
      summarize;
   end
endmodule
bind mxbar_switch mxbar_switch_monitor mxbar_switch_monitor_inst(.core_clk(core_clk),
   .rst_b(rst_b), .m_req(m_req), .m_ifetch(m_ifetch), .m_sel(m_sel), .m_grant(m_grant),
   .m_done(m_done), .s_req(s_req), .s_done(s_done));
